// ---- hdl/vtc_command_timing.sv ----
`timescale 1ns/1ps
`include "vtc_defs.svh"
module vtc_command_timing
    import vtc_pkg::*;
#(
    parameter int unsigned REPLY_DELAY = `TAG_REPLY_NOM,
    parameter int unsigned FIELD_GUARD = `RF_GUARD_CYC
) (
    // system clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // link side, carrier clock domain
    input  wire logic     carrierClk,
    input  wire logic     fieldOn,
    input  wire logic     reqDone,
    input  wire vtc_req_t req,
    // response to the frame encoder
    output logic          respValid,
    output vtc_resp_t     resp
);

    // ========================================
    // link domain: synchronisers, guard, request hold and reply timing state
    logic            lkRstMeta_r;
    logic            lkRst_r;
    logic            fieldMeta_r;
    logic            fieldSync_r;
    logic [15:0]     guardCnt_r;
    logic            guardDone_r;
    logic            reqTgl_r;
    vtc_req_t        reqHold_r;
    vtc_link_state_t lkState_r;
    logic [15:0]     waitCnt_r;
    logic            gotResp_r;
    vtc_resp_t       respLk_r;
    logic            respMeta_r;
    logic            respSync_r;
    logic            respSeen_r;
    logic            respValid_r;
    vtc_resp_t       resp_r;

    // ========================================
    // core domain state
    logic            reqMeta_r;
    logic            reqSync_r;
    logic            reqSeen_r;
    logic            respTgl_r;
    vtc_resp_t       respHold_r;
    vtc_tag_state_t  tagState_r;
    logic [31:0]     mem_r [`MEM_BLOCKS];
    logic [15:0]     blkLock_r;
    logic [7:0]      afi_r;
    logic [7:0]      dsfid_r;
    logic            afiLock_r;
    logic            dsfidLock_r;
    logic [63:0]     pwd_r [4];
    logic [3:0]      sess_r;
    logic [7:0]      cfg_r [`CFG_REGS];

    // ========================================
    // shared helpers
    function automatic logic [1:0] areaOf(input logic [3:0] b);
        areaOf = b[3:2];
    endfunction

    // ========================================
    // link decodes
    wire       linkEdge   = lkState_r == LK_WAIT;
    wire       delayDone  = waitCnt_r == 16'(REPLY_DELAY - 1);
    wire       respArrive = respSync_r ^ respSeen_r;
    wire       takeReq    = reqDone & guardDone_r;
    wire       emitNow    = linkEdge & delayDone & gotResp_r;
    // reset sync into the carrier domain
    always_ff @(posedge carrierClk) begin
        lkRstMeta_r <= rst;
        lkRst_r     <= lkRstMeta_r;
    end
    // field level and response toggle synchronisers
    always_ff @(posedge carrierClk) begin
        fieldMeta_r <= fieldOn;
        fieldSync_r <= fieldMeta_r;
        respMeta_r  <= respTgl_r;
        respSync_r  <= respMeta_r;
    end
    // power-up guard counted in carrier periods
    always_ff @(posedge carrierClk) begin
        if (lkRst_r || !fieldSync_r) begin
            guardCnt_r  <= 16'h0000;
            guardDone_r <= 1'b0;
        end else if (!guardDone_r) begin
            guardCnt_r  <= guardCnt_r + 16'h0001;
            guardDone_r <= guardCnt_r == 16'(FIELD_GUARD - 1);
        end
    end
    // request capture; either modulation of frame end lands here
    always_ff @(posedge carrierClk) begin
        if (lkRst_r) begin
            reqTgl_r  <= 1'b0;
            reqHold_r <= '0;
        end else if (takeReq) begin
            reqHold_r <= req;
            reqTgl_r  <= ~reqTgl_r;
        end
    end
    // reply delay counter and response release
    always_ff @(posedge carrierClk) begin
        if (lkRst_r) begin
            lkState_r   <= LK_IDLE;
            waitCnt_r   <= 16'h0000;
            gotResp_r   <= 1'b0;
            respSeen_r  <= 1'b0;
            respLk_r    <= '0;
            respValid_r <= 1'b0;
            resp_r      <= '0;
        end else begin
            respSeen_r  <= respSync_r;
            respValid_r <= 1'b0;
            if (takeReq) begin
                // reader keeps its own spacing after a reply
                lkState_r <= LK_WAIT;
                waitCnt_r <= 16'h0000;
                gotResp_r <= 1'b0;
            end else begin
                if (respArrive) begin
                    gotResp_r <= 1'b1;
                    respLk_r  <= respHold_r;
                end
                if (linkEdge && !delayDone) begin
                    waitCnt_r <= waitCnt_r + 16'h0001;
                end
                // late write answers go out when ready
                if (emitNow) begin
                    lkState_r   <= LK_IDLE;
                    respValid_r <= ~respLk_r.noReply;
                    resp_r      <= respLk_r;
                end
            end
        end
    end
    // outputs from link flops
    assign respValid = respValid_r;
    assign resp      = resp_r;

    // ========================================
    // core: request toggle synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            reqMeta_r <= 1'b0;
            reqSync_r <= 1'b0;
            reqSeen_r <= 1'b0;
        end else begin
            reqMeta_r <= reqTgl_r;
            reqSync_r <= reqMeta_r;
            reqSeen_r <= reqSync_r;
        end
    end

    // ========================================
    // core decodes; request hold is stable once the toggle arrives
    wire           exec    = reqSync_r ^ reqSeen_r;
    wire vtc_req_t q       = reqHold_r;
    wire           isMulti = q.op inside {OP_READ_MULTI, OP_WRITE_MULTI};
    wire [1:0]     nCnt    = isMulti ? q.cnt : 2'h0;
    wire [8:0]     blkEnd  = {1'b0, q.blk} + {7'h00, nCnt};
    wire           rangeOk = blkEnd < 9'(`MEM_BLOCKS);
    wire [3:0]     b0      = q.blk[3:0];
    wire [3:0]     bN      = blkEnd[3:0];
    wire           oneArea = areaOf(b0) == areaOf(bN);
    wire           selMiss = q.selFlag & (tagState_r != TS_SELECTED);
    wire           adrMiss = q.addrFlag & ~q.uidMatch;
    wire           quietInv = q.invFlag & (tagState_r == TS_QUIET);
    wire           accept  = ~selMiss & ~adrMiss & ~quietInv;
    wire           pwdOk   = pwd_r[q.pwdId] == q.pwd;
    wire [7:0]     protCfg = cfg_r[`CFG_PROT];
    // lock and protection scan over requested blocks
    logic          anyWrLk;
    logic          anyRdLk;
    logic [127:0]  rdData;
    logic [3:0]    rdLock;
    always_comb begin
        logic [3:0] b;
        b = 4'h0;
        anyWrLk = 1'b0;
        anyRdLk = 1'b0;
        rdData  = '0;
        rdLock  = 4'h0;
        for (int i = 0; i < 4; i++) begin
            b = b0 + 4'(i);
            if (2'(i) <= nCnt) begin
                anyWrLk |= blkLock_r[b] |
                           (areaOf(b) != 2'h0 && protCfg[areaOf(b)] && !sess_r[areaOf(b)]);
                anyRdLk |= areaOf(b) != 2'h0 && protCfg[4 + areaOf(b)] && !sess_r[areaOf(b)];
                rdData[32*i +: 32] = mem_r[b];
                rdLock[i] = blkLock_r[b];
            end
        end
    end
    // command execution
    vtc_resp_t      rN;
    vtc_tag_state_t tagState_nxt;
    logic           wrBlk;
    logic           lockBlk;
    logic           afiWe;
    logic           afiLk;
    logic           dsfWe;
    logic           dsfLk;
    logic           pwdWe;
    logic           sessSet;
    logic           cfgWe;
    always_comb begin
        rN      = '0;
        rN.fast = q.fast;
        tagState_nxt = tagState_r;
        wrBlk   = 1'b0;
        lockBlk = 1'b0;
        afiWe   = 1'b0;
        afiLk   = 1'b0;
        dsfWe   = 1'b0;
        dsfLk   = 1'b0;
        pwdWe   = 1'b0;
        sessSet = 1'b0;
        cfgWe   = 1'b0;
        if (!accept) begin
            rN.noReply = 1'b1;
        end else if (q.fmtErr) begin
            rN.errCode = `ERR_FORMAT;
        end else begin
            case (q.op)
                OP_INVENTORY: begin
                    rN.data[7:0] = dsfid_r;
                end
                OP_STAY_QUIET: begin
                    rN.noReply = 1'b1;
                    tagState_nxt = TS_QUIET;
                end
                OP_SELECT: begin
                    if (q.optFlag) rN.errCode = `ERR_OPTION;
                    else tagState_nxt = TS_SELECTED;
                end
                OP_RESET_READY: begin
                    if (q.optFlag) rN.errCode = `ERR_OPTION;
                    else tagState_nxt = TS_READY;
                end
                OP_READ_SINGLE, OP_READ_MULTI: begin
                    if (!rangeOk) rN.errCode = `ERR_BLK_NA;
                    else if (!oneArea) rN.errCode = `ERR_NOINFO;
                    else if (anyRdLk) rN.errCode = `ERR_RDPROT;
                    else begin
                        rN.data   = rdData;
                        rN.lockBits = rdLock;
                    end
                end
                OP_WRITE_SINGLE, OP_WRITE_MULTI: begin
                    if (!rangeOk) rN.errCode = `ERR_BLK_NA;
                    else if (!oneArea) rN.errCode = `ERR_NOINFO;
                    else if (anyWrLk) rN.errCode = `ERR_BLK_RO;
                    else wrBlk = 1'b1;
                end
                OP_LOCK_BLOCK: begin
                    if (!rangeOk) rN.errCode = `ERR_BLK_NA;
                    else if (b0 != `CONTAINER_BLK) rN.errCode = `ERR_LOCK;
                    else if (blkLock_r[b0]) rN.errCode = `ERR_BLK_LOCKED;
                    else lockBlk = 1'b1;
                end
                OP_WRITE_AFI: begin
                    if (afiLock_r) rN.errCode = `ERR_BLK_RO;
                    else afiWe = 1'b1;
                end
                OP_LOCK_AFI: begin
                    if (afiLock_r) rN.errCode = `ERR_BLK_LOCKED;
                    else afiLk = 1'b1;
                end
                OP_WRITE_DSFID: begin
                    if (dsfidLock_r) rN.errCode = `ERR_BLK_RO;
                    else dsfWe = 1'b1;
                end
                OP_LOCK_DSFID: begin
                    if (dsfidLock_r) rN.errCode = `ERR_BLK_LOCKED;
                    else dsfLk = 1'b1;
                end
                OP_WRITE_PWD: begin
                    if (!sess_r[q.pwdId]) rN.errCode = `ERR_NOINFO;
                    else pwdWe = 1'b1;
                end
                OP_PRESENT_PWD: begin
                    if (!pwdOk) rN.errCode = `ERR_NOINFO;
                    else sessSet = 1'b1;
                end
                OP_READ_CFG: begin
                    rN.data[7:0] = cfg_r[q.cfgIdx];
                end
                OP_WRITE_CFG: begin
                    if (!sess_r[0]) rN.errCode = `ERR_NOINFO;
                    else cfgWe = 1'b1;
                end
                default: begin
                    rN.errCode = `ERR_UNSUP;
                end
            endcase
        end
        rN.errFlag = rN.errCode != `ERR_NONE;
        if (rN.errFlag) begin
            rN.data   = '0;
            rN.lockBits = 4'h0;
        end
    end
    // response hand-back and tag state
    always_ff @(posedge clk) begin
        if (rst) begin
            respTgl_r  <= 1'b0;
            respHold_r <= '0;
            tagState_r <= TS_READY;
        end else if (exec) begin
            respHold_r <= rN;
            respTgl_r  <= ~respTgl_r;
            tagState_r <= tagState_nxt;
        end
    end
    // block memory and lock bits
    always_ff @(posedge clk) begin
        if (rst) begin
            blkLock_r <= 16'h0000;
        end else if (exec && lockBlk) begin
            blkLock_r[b0] <= 1'b1;
        end
        if (exec && wrBlk) begin
            for (int i = 0; i < 4; i++) begin
                if (2'(i) <= nCnt) mem_r[b0 + 4'(i)] <= q.data[32*i +: 32];
            end
        end
    end
    // identifier bytes, passwords, sessions, configuration
    always_ff @(posedge clk) begin
        if (rst) begin
            afi_r       <= `BYTE_RST;
            dsfid_r     <= `BYTE_RST;
            afiLock_r   <= 1'b0;
            dsfidLock_r <= 1'b0;
            sess_r      <= 4'h0;
            for (int i = 0; i < 4; i++) pwd_r[i] <= `PWD_RST;
            for (int i = 0; i < `CFG_REGS; i++) cfg_r[i] <= `CFG_RST;
        end else if (exec) begin
            if (afiWe) afi_r <= q.val;
            if (afiLk) afiLock_r <= 1'b1;
            if (dsfWe) dsfid_r <= q.val;
            if (dsfLk) dsfidLock_r <= 1'b1;
            if (pwdWe) pwd_r[q.pwdId] <= q.pwd;
            if (sessSet) sess_r[q.pwdId] <= 1'b1;
            if (cfgWe) cfg_r[q.cfgIdx] <= q.val;
        end
    end

    // ========================================
    // checks: core domain
    sequence selExec;
        exec && accept && !q.fmtErr && q.op == OP_SELECT && !q.optFlag;
    endsequence
    sequence quietExec;
        exec && accept && !q.fmtErr && q.op == OP_STAY_QUIET;
    endsequence
    AST_SELECT_STATE: assert property (@(posedge clk) disable iff (rst)
        selExec |=> tagState_r == TS_SELECTED && !respHold_r.errFlag)
        else $error("select did not enter selected state");
    AST_QUIET_ENTER: assert property (@(posedge clk) disable iff (rst)
        quietExec |=> tagState_r == TS_QUIET && respHold_r.noReply)
        else $error("stay quiet did not silence the tag");
    AST_QUIET_INV: assert property (@(posedge clk) disable iff (rst)
        exec && tagState_r == TS_QUIET && q.invFlag |=> respHold_r.noReply)
        else $error("quiet tag answered an inventory");
    AST_READY_STATE: assert property (@(posedge clk) disable iff (rst)
        exec && accept && !q.fmtErr && q.op == OP_RESET_READY && !q.optFlag |=> tagState_r == TS_READY)
        else $error("reset to ready did not enter ready");
    AST_UNSUP_CODE: assert property (@(posedge clk) disable iff (rst)
        exec && accept && !q.fmtErr && q.op == OP_OTHER |=> respHold_r.errCode == `ERR_UNSUP)
        else $error("unsupported command not reported");
    AST_ERR_FIELD: assert property (@(posedge clk) disable iff (rst)
        $changed(respTgl_r) |-> respHold_r.errFlag == (respHold_r.errCode != `ERR_NONE))
        else $error("error flag and code disagree");
    AST_WR_LOCKED: assert property (@(posedge clk) disable iff (rst)
        exec && accept && !q.fmtErr && q.op == OP_WRITE_SINGLE && rangeOk && blkLock_r[b0]
        |=> respHold_r.errCode == `ERR_BLK_RO)
        else $error("write to locked block not refused");
    AST_AFI_HOLD: assert property (@(posedge clk) disable iff (rst)
        afiLock_r |=> $stable(afi_r) && afiLock_r)
        else $error("locked family byte changed");
    AST_PWD_REFUSE: assert property (@(posedge clk) disable iff (rst)
        exec && accept && !q.fmtErr && q.op == OP_WRITE_PWD && !sess_r[q.pwdId]
        |=> respHold_r.errCode == `ERR_NOINFO)
        else $error("password replaced without session");
    // checks: link domain
    AST_REPLY_DELAY: assert property (@(posedge carrierClk) disable iff (lkRst_r)
        respValid_r |-> $past(waitCnt_r) == 16'(REPLY_DELAY - 1))
        else $error("reply released off the nominal delay");
    AST_GUARD_IGNORE: assert property (@(posedge carrierClk) disable iff (lkRst_r)
        !guardDone_r |=> $stable(reqTgl_r))
        else $error("request taken inside power-up guard");
endmodule

// ---- hdl/vtc_defs.svh ----
`ifndef VTC_DEFS_SVH
`define VTC_DEFS_SVH
// Contract
// - generic errors 01h 02h 03h 0Fh
// - block errors 10h through 15h
// - reply 4352 periods after reader frame end
// - write replies may exceed maximum delay
// - requests ignored just after field rise
// - timings held within 32 carrier periods
// - select enters selected state
// - stay quiet silences inventory answers
// - reset to ready enters ready state
// - single read returns word and lock
// - single write only outside locked area
// - multiple read within one area only
// - multiple write up to four blocks
// - family and format bytes, writable, lockable
// - password change needs current password first
// - correct password opens security session
// - block lock protects container blocks
// - fast reads same content, double rate
// - configuration registers read and write
// - error flag set, code follows

// ========================================
// error codes
`define ERR_NONE       8'h00
`define ERR_UNSUP      8'h01
`define ERR_FORMAT     8'h02
`define ERR_OPTION     8'h03
`define ERR_NOINFO     8'h0F
`define ERR_BLK_NA     8'h10
`define ERR_BLK_LOCKED 8'h11
`define ERR_BLK_RO     8'h12
`define ERR_PROG       8'h13
`define ERR_LOCK       8'h14
`define ERR_RDPROT     8'h15

// ========================================
// timing in carrier periods
`define TAG_REPLY_MIN  4320
`define TAG_REPLY_NOM  4352
`define TAG_REPLY_MAX  4384
`define READER_NEW_MIN 4192
`define TIMING_TOL     32
`define RF_GUARD_CYC   13560

// ========================================
// memory layout and reset values
`define MEM_BLOCKS     16
`define CONTAINER_BLK  4'h0
`define CFG_REGS       8
`define CFG_PROT       3'h0
`define CFG_RST        8'h00
`define PWD_RST        64'h0
`define BYTE_RST       8'h00
`endif

// ---- hdl/vtc_pkg.sv ----
package vtc_pkg;
`include "vtc_defs.svh"

    // decoded operations from the frame decoder
    typedef enum logic [4:0] {
        OP_INVENTORY, OP_STAY_QUIET, OP_SELECT, OP_RESET_READY,
        OP_READ_SINGLE, OP_WRITE_SINGLE, OP_LOCK_BLOCK, OP_READ_MULTI,
        OP_WRITE_MULTI, OP_WRITE_AFI, OP_LOCK_AFI, OP_WRITE_DSFID,
        OP_LOCK_DSFID, OP_WRITE_PWD, OP_PRESENT_PWD, OP_READ_CFG,
        OP_WRITE_CFG, OP_OTHER
    } vtc_op_t;

    // tag protocol state
    typedef enum logic [1:0] {TS_READY, TS_QUIET, TS_SELECTED} vtc_tag_state_t;

    // link timing state
    typedef enum logic {LK_IDLE, LK_WAIT} vtc_link_state_t;

    // one decoded request
    typedef struct packed {
        vtc_op_t      op;
        logic         selFlag;
        logic         addrFlag;
        logic         uidMatch;
        logic         invFlag;
        logic         optFlag;
        logic         fmtErr;
        logic         fast;
        logic [7:0]   blk;
        logic [1:0]   cnt;
        logic [1:0]   pwdId;
        logic [63:0]  pwd;
        logic [2:0]   cfgIdx;
        logic [7:0]   val;
        logic [127:0] data;
    } vtc_req_t;

    // one response
    typedef struct packed {
        logic         noReply;
        logic         errFlag;
        logic [7:0]   errCode;
        logic         fast;
        logic [3:0]   lockBits;
        logic [127:0] data;
    } vtc_resp_t;
endpackage

// ---- verif/vtc_reader_model.sv ----
`timescale 1ns/1ps
// ========================================
// reader on the far side of the link
module vtc_reader_model
    import vtc_pkg::*;
#(
    parameter int unsigned REPLY_DELAY = 40
) (
    // carrier clock
    input  wire logic      carrierClk,
    // request towards the tag
    output logic           reqDone,
    output vtc_req_t       req,
    // response from the tag
    input  wire logic      respValid,
    input  wire vtc_resp_t resp
);
    localparam int unsigned NEW_GAP = 4192;

    // idle link before the first frame
    initial begin
        reqDone = 1'b0;
        req     = '0;
    end

    // one frame end, wait for the answer, then keep the request gap
    task automatic send(input vtc_req_t r, output logic got, output int unsigned lat);
        @(negedge carrierClk);
        reqDone = 1'b1;
        req     = r;
        @(negedge carrierClk);
        reqDone = 1'b0;
        req     = ~r;   // stale fields must not be relied on
        lat     = 1;
        while (respValid !== 1'b1 && lat < REPLY_DELAY + 40) begin
            @(negedge carrierClk);
            lat++;
        end
        got = (respValid === 1'b1);
        repeat (NEW_GAP) @(negedge carrierClk);
    endtask
endmodule

// ---- verif/tb_vtc_command_timing.sv ----
`timescale 1ns/1ps
module tb_vtc_command_timing;
    import vtc_pkg::*;
    localparam int unsigned REPLY_DELAY = 40;
    localparam int unsigned FIELD_GUARD = 20;
    localparam logic [31:0] W           = 32'hA5A51234;

    // one table row: request and expected answer
    typedef struct {
        vtc_req_t    rq;
        logic        got;
        logic [7:0]  code;
        logic [31:0] word;
    } vtc_row_t;

    logic        clk        = 1'b0;
    logic        carrierClk = 1'b0;
    logic        rst        = 1'b1;
    logic        fieldOn    = 1'b1;
    logic        reqDone;
    logic        respValid;
    logic        got;
    vtc_req_t    req;
    vtc_resp_t   resp;
    int unsigned lat;
    int          errCount   = 0;
    int          nTests     = 0;
    vtc_row_t    rows[$];
    vtc_row_t    oneRow;

    // ========================================
    // clocks and instances
    always #10 clk = ~clk;
    always #7.5 carrierClk = ~carrierClk;

    vtc_command_timing #(.REPLY_DELAY(REPLY_DELAY), .FIELD_GUARD(FIELD_GUARD)) i_dut (
        .clk(clk), .rst(rst), .carrierClk(carrierClk), .fieldOn(fieldOn),
        .reqDone(reqDone), .req(req), .respValid(respValid), .resp(resp));

    vtc_reader_model #(.REPLY_DELAY(REPLY_DELAY)) i_rdr (
        .carrierClk(carrierClk), .reqDone(reqDone), .req(req), .respValid(respValid), .resp(resp));

    // ========================================
    // helpers
    function automatic vtc_row_t mk(vtc_op_t op, logic [7:0] blk, logic [7:0] f, logic [7:0] val,
                                    logic g, logic [7:0] code, logic [31:0] word);
        vtc_row_t w;
        w.rq          = '0;
        w.rq.op       = op;
        w.rq.blk      = blk;
        w.rq.cnt      = f[5:4];
        w.rq.selFlag  = f[0];
        w.rq.optFlag  = f[1];
        w.rq.fmtErr   = f[2];
        w.rq.fast     = f[3];
        w.rq.invFlag  = (op == OP_INVENTORY);
        w.rq.addrFlag = !f[0] && op != OP_INVENTORY;
        w.rq.uidMatch = 1'b1;
        w.rq.val      = val;
        w.rq.pwdId    = val[1:0];
        w.rq.data     = {W + 32'h3, W + 32'h2, W + 32'h1, W};
        w.got         = g;
        w.code        = code;
        w.word        = word;
        return w;
    endfunction

    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic testDone();
        $display("checks %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ========================================
    // watchdog against a hang
    initial begin
        #3_000_000;
        errCount++;
        testDone();
    end

    // ========================================
    // main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (FIELD_GUARD + 5) @(negedge carrierClk);
        rows = '{
            mk(OP_WRITE_SINGLE, 8'h05, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_READ_SINGLE,  8'h05, 8'h00, 8'h00, 1'b1, 8'h00, W),
            mk(OP_READ_SINGLE,  8'h10, 8'h00, 8'h00, 1'b1, 8'h10, 32'h0),
            mk(OP_OTHER,        8'h00, 8'h00, 8'h00, 1'b1, 8'h01, 32'h0),
            mk(OP_READ_SINGLE,  8'h05, 8'h04, 8'h00, 1'b1, 8'h02, 32'h0),
            mk(OP_SELECT,       8'h00, 8'h02, 8'h00, 1'b1, 8'h03, 32'h0),
            mk(OP_WRITE_MULTI,  8'h08, 8'h30, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_READ_MULTI,   8'h09, 8'h20, 8'h00, 1'b1, 8'h00, W + 32'h1),
            mk(OP_READ_MULTI,   8'h07, 8'h10, 8'h00, 1'b1, 8'h0F, 32'h0),
            mk(OP_WRITE_AFI,    8'h00, 8'h00, 8'h3C, 1'b1, 8'h00, 32'h0),
            mk(OP_LOCK_AFI,     8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_WRITE_AFI,    8'h00, 8'h00, 8'h3C, 1'b1, 8'h12, 32'h0),
            mk(OP_WRITE_DSFID,  8'h00, 8'h00, 8'h5A, 1'b1, 8'h00, 32'h0),
            mk(OP_INVENTORY,    8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h5A),
            mk(OP_LOCK_BLOCK,   8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_LOCK_BLOCK,   8'h00, 8'h00, 8'h00, 1'b1, 8'h11, 32'h0),
            mk(OP_LOCK_BLOCK,   8'h01, 8'h00, 8'h00, 1'b1, 8'h14, 32'h0),
            mk(OP_WRITE_SINGLE, 8'h00, 8'h00, 8'h00, 1'b1, 8'h12, 32'h0),
            mk(OP_WRITE_PWD,    8'h00, 8'h00, 8'h01, 1'b1, 8'h0F, 32'h0),
            mk(OP_PRESENT_PWD,  8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_WRITE_CFG,    8'h00, 8'h00, 8'h02, 1'b1, 8'h00, 32'h0),
            mk(OP_READ_CFG,     8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h02),
            mk(OP_WRITE_SINGLE, 8'h05, 8'h00, 8'h00, 1'b1, 8'h12, 32'h0),
            mk(OP_READ_SINGLE,  8'h05, 8'h08, 8'h00, 1'b1, 8'h00, W),
            mk(OP_STAY_QUIET,   8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 32'h0),
            mk(OP_INVENTORY,    8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 32'h0),
            mk(OP_SELECT,       8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_READ_SINGLE,  8'h05, 8'h01, 8'h00, 1'b1, 8'h00, W),
            mk(OP_RESET_READY,  8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0),
            mk(OP_READ_SINGLE,  8'h05, 8'h01, 8'h00, 1'b0, 8'h00, 32'h0)};
        // table walk: each row is one request and its answer
        foreach (rows[i]) begin
            i_rdr.send(rows[i].rq, got, lat);
            chk(got, rows[i].got);
            if (got === 1'b1) begin
                chk(lat, REPLY_DELAY + 1);
                chk(resp.errFlag, rows[i].code != 8'h00);
                chk(resp.errCode, rows[i].code);
                chk(resp.data[31:0], rows[i].word);
                chk(resp.fast, rows[i].rq.fast);
                chk(resp.lockBits, 4'h0);
            end
        end
        // reset in mid-run clears outputs and locks
        @(negedge clk);
        rst = 1'b1;
        repeat (6) @(negedge clk);
        chk(respValid, 1'b0);
        chk(resp, '0);
        rst = 1'b0;
        // request inside the guard after release is ignored
        oneRow = mk(OP_WRITE_AFI, 8'h00, 8'h00, 8'h3C, 1'b1, 8'h00, 32'h0);
        i_rdr.send(oneRow.rq, got, lat);
        chk(got, 1'b0);
        i_rdr.send(oneRow.rq, got, lat);
        chk(got, 1'b1);
        chk(resp.errCode, 8'h00);
        // field drop restarts the guard
        @(negedge carrierClk);
        fieldOn = 1'b0;
        repeat (10) @(negedge carrierClk);
        fieldOn = 1'b1;
        oneRow = mk(OP_READ_CFG, 8'h00, 8'h00, 8'h00, 1'b1, 8'h00, 32'h0);
        i_rdr.send(oneRow.rq, got, lat);
        chk(got, 1'b0);
        testDone();
    end
endmodule
